// *** rtl/pmkd_params.svh ***
// Constants of the panel meter key and display control.
// Included by the design files; holds definitions only.
`ifndef PMKD_PARAMS_SVH
`define PMKD_PARAMS_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PMKD_CLK_HZ 10000000
`define PMKD_CYC_PER_MS (`PMKD_CLK_HZ / 1000)
`define PMKD_IDLE_MS 10000
`define PMKD_TEST_MS 1000
`define PMKD_SWTYPE_MS 1000
`define PMKD_SWVER_MS 1000
`define PMKD_FLASH_MS 500
`define PMKD_DEBOUNCE_MS 20

// ----------------------------------------------------------------
// Display symbols, five bits per digit
// ----------------------------------------------------------------
`define PMKD_SYM_NINE 5'h09
`define PMKD_SYM_MINUS 5'h0A
`define PMKD_SYM_BAR_HI 5'h0B
`define PMKD_SYM_BAR_LO 5'h0C
`define PMKD_SYM_ALL 5'h0D
`define PMKD_SYM_BLANK 5'h0E
`define PMKD_SYM_PROG 5'h0F

// ----------------------------------------------------------------
// Entry and menu layout
// ----------------------------------------------------------------
`define PMKD_DIGIT_TOP 2'h3
`define PMKD_N_TYPES 3'h5
`define PMKD_N_KEYF 3'h3
`define PMKD_KEY_PROG 0
`define PMKD_KEY_PLUS 1
`define PMKD_KEY_MINUS 2

`endif

// *** rtl/pmkd_pkg.sv ***
// Types of the panel meter key and display control.
// Constants live in pmkd_params.svh.
package pmkd_pkg;
    typedef enum {S_TEST, S_SWTYPE, S_SWVER, S_OPER, S_MENU, S_CHOICE, S_NUM} pmkd_state_t;
    typedef enum logic [2:0] {IT_VOLT, IT_CURR, IT_RTD, IT_TC, IT_PULSE} pmkd_in_type_t;
    typedef enum logic [1:0] {KF_NONE, KF_MINMAX, KF_LIMIT} pmkd_keyf_t;
    typedef enum logic [1:0] {ITEM_TYPE, ITEM_KEYF, ITEM_LIMLO, ITEM_END} pmkd_item_t;
    typedef enum {RC_LIVE, RC_MIN, RC_MAX} pmkd_recall_t;
    typedef logic [3:0][4:0] pmkd_disp_t;
endpackage

// *** rtl/pmkd_key_if.sv ***
// Key events from the debouncer to the control core.
// Each signal is a one-cycle pulse on clk_sys_in.
`timescale 1ns/1ps
`default_nettype none
interface pmkd_key_if;
    logic prog;
    logic plus;
    logic minus;
    modport src (output prog, output plus, output minus);
    modport dst (input prog, input plus, input minus);
endinterface
`default_nettype wire

// *** rtl/pmkd_key_debounce.sv ***
// Debouncer for the three front keys.
// Assumes raw key levels, active high, asynchronous to clk_sys_in.
`timescale 1ns/1ps
`default_nettype none
`include "pmkd_params.svh"
module pmkd_key_debounce import pmkd_pkg::*; #(
    parameter int DEB_CYC = `PMKD_DEBOUNCE_MS * `PMKD_CYC_PER_MS
) (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    // Raw keys
    input wire logic [2:0] key_raw_in,
    // Key events
    pmkd_key_if.src keys
);
    if (DEB_CYC < 2) begin : g_chk
        $error("DEB_CYC must be at least 2");
    end

    logic [2:0] ev;

    for (genvar i = 0; i < 3; i++) begin : g_key
        logic q1, q2, q3, stable;
        logic [31:0] cnt;
        always_ff @(posedge clk_sys_in) begin
            if (!nrst_in) begin
                q1 <= 1'b0;
                q2 <= 1'b0;
                q3 <= 1'b0;
            end else begin
                q1 <= key_raw_in[i];
                q2 <= q1;
                q3 <= q2;
            end
        end
        // A level must hold for DEB_CYC agreeing samples before it counts.
        always_ff @(posedge clk_sys_in) begin
            if (!nrst_in) begin
                cnt <= 32'h0;
                stable <= 1'b0;
                ev[i] <= 1'b0;
            end else begin
                ev[i] <= 1'b0;
                if (q2 != q3 || q3 == stable) begin
                    cnt <= 32'h0;
                end else if (cnt == 32'(DEB_CYC - 1)) begin
                    cnt <= 32'h0;
                    stable <= q3;
                    ev[i] <= q3;
                end else begin
                    cnt <= cnt + 32'h1;
                end
            end
        end
        property p_one_event;
            @(posedge clk_sys_in) disable iff (!nrst_in)
            ev[i] |=> !ev[i] [*2];
        endproperty
        a_one_event: assert property (p_one_event) else $error("key event repeated");
    end

    assign keys.prog = ev[`PMKD_KEY_PROG];
    assign keys.plus = ev[`PMKD_KEY_PLUS];
    assign keys.minus = ev[`PMKD_KEY_MINUS];
endmodule
`default_nettype wire

// *** rtl/pmkd_core.sv ***
// Front-panel control of a four-digit panel meter: keys, menu, entry, display.
// Assumes measured, min and max values arrive as digit symbols on clk_sys_in,
// and switching-point and over/underflow flags come from logic on the same clock.
//
// Behaviour
// - Ten seconds without key press in parameterisation saves pending edits, returns.
// - Display flashes while the shown item is adjustable.
// - Program key enters parameterisation, descends a level or opens value.
// - Plus/minus step parameters at menu level, change value at value level.
// - In operation plus/minus do the configured key function.
// - Active switching point flashes its indicator LED.
// - Overflow or underflow shows four bars instead of a number.
// - Entry runs least to most digit, program confirms, then back to menu.
// - Minus sign selectable only on the leftmost digit.
// - Power-up: segment test 1 s, software type, version 1 s, operate.
// - Input type has five choices, each selecting its processing path.
// - External reset input clears the count in counter use.
`timescale 1ns/1ps
`default_nettype none
`include "pmkd_params.svh"
module pmkd_core import pmkd_pkg::*; #(
    // One setting scales every timing count, so a faster clock needs one change.
    parameter int CYC_PER_MS = `PMKD_CYC_PER_MS,
    parameter int IDLE_CYC = `PMKD_IDLE_MS * CYC_PER_MS,
    parameter int TEST_CYC = `PMKD_TEST_MS * CYC_PER_MS,
    parameter int SWTYPE_CYC = `PMKD_SWTYPE_MS * CYC_PER_MS,
    parameter int SWVER_CYC = `PMKD_SWVER_MS * CYC_PER_MS,
    parameter int FLASH_CYC = `PMKD_FLASH_MS * CYC_PER_MS,
    parameter int DEB_CYC = `PMKD_DEBOUNCE_MS * CYC_PER_MS,
    // Arbitrary identification symbols.
    parameter pmkd_disp_t SW_TYPE = 20'h0_8421,
    parameter pmkd_disp_t SW_VER = 20'h0_0401
) (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    // Front keys, raw, active high
    input wire logic [2:0] key_raw_in,
    // Measurement path
    input wire pmkd_disp_t meas_digits_in,
    input wire pmkd_disp_t min_digits_in,
    input wire pmkd_disp_t max_digits_in,
    input wire logic meas_over_in,
    input wire logic meas_under_in,
    // Switching points and counter reset pin
    input wire logic [1:0] sp_active_in,
    input wire logic count_reset_in,
    // Display and indicators
    output pmkd_disp_t disp_out,
    output logic disp_blank_out,
    output logic [1:0] sp_led_out,
    output logic switch_output_one_out,
    output logic switch_output_two_out,
    // Settings and actions
    output pmkd_in_type_t in_type_out,
    output logic [4:0] path_sel_out,
    output pmkd_keyf_t keyf_out,
    output pmkd_disp_t lim_lo_out,
    output logic count_clear_out
);
    if (CYC_PER_MS < 1 || IDLE_CYC < 2 || TEST_CYC < 1 || SWTYPE_CYC < 1 || SWVER_CYC < 1
        || FLASH_CYC < 1)
    begin : g_chk
        $error("timing counts too small");
    end

    pmkd_key_if keys ();
    pmkd_key_debounce #(.DEB_CYC(DEB_CYC)) u_deb (
        .clk_sys_in(clk_sys_in),
        .nrst_in(nrst_in),
        .key_raw_in(key_raw_in),
        .keys(keys)
    );

    pmkd_state_t state;
    pmkd_item_t sel;
    pmkd_recall_t recall;
    pmkd_disp_t pend_dig;
    logic [2:0] pend_choice;
    logic [1:0] dig_idx;
    logic [31:0] boot_tmr, idle_cnt, flash_cnt;
    logic flash_phase, lim_show, boot_end, idle_end, timeout, in_param, any_key;
    logic num_done, flash_on;
    logic cr_q1, cr_q2, cr_q3, cr_stable;

    // Returns the next symbol of one digit; only the leftmost one may take the sign.
    function automatic logic [4:0] step_digit(input logic [4:0] d, input logic up,
                                              input logic top);
        logic [4:0] last;
        last = top ? `PMKD_SYM_MINUS : `PMKD_SYM_NINE;
        if (up) begin
            step_digit = (d >= last) ? 5'h00 : d + 5'h01;
        end else begin
            step_digit = (d == 5'h00 || d > last) ? last : d - 5'h01;
        end
    endfunction

    // Adds or subtracts one on the magnitude with carry; a sign flips the direction.
    function automatic pmkd_disp_t step_value(input pmkd_disp_t v, input logic up);
        logic carry;
        logic dir;
        step_value = v;
        carry = 1'b1;
        dir = (v[3] == `PMKD_SYM_MINUS) ? !up : up;
        for (int i = 0; i < 4; i++) begin
            if (carry && v[i] <= `PMKD_SYM_NINE) begin
                carry = dir ? (v[i] == `PMKD_SYM_NINE) : (v[i] == 5'h00);
                step_value[i] = step_digit(v[i], dir, 1'b0);
            end
        end
    endfunction

    assign any_key = keys.prog || keys.plus || keys.minus;
    assign in_param = state == S_MENU || state == S_CHOICE || state == S_NUM;
    assign idle_end = idle_cnt == 32'(IDLE_CYC - 1);
    assign timeout = in_param && idle_end && !any_key;
    assign num_done = state == S_NUM && keys.prog && dig_idx == `PMKD_DIGIT_TOP;
    assign boot_end = (state == S_TEST && boot_tmr == 32'(TEST_CYC - 1))
        || (state == S_SWTYPE && boot_tmr == 32'(SWTYPE_CYC - 1))
        || (state == S_SWVER && boot_tmr == 32'(SWVER_CYC - 1));
    assign flash_on = state == S_CHOICE || state == S_NUM || (state == S_OPER && lim_show);

    // ----------------------------------------------------------------
    // Timers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_in) begin
        if (!nrst_in || boot_end) begin
            boot_tmr <= 32'h0;
        end else begin
            boot_tmr <= boot_tmr + 32'h1;
        end
    end

    // Any key restarts the inactivity window.
    always_ff @(posedge clk_sys_in) begin
        if (!nrst_in || any_key || idle_end) begin
            idle_cnt <= 32'h0;
        end else begin
            idle_cnt <= idle_cnt + 32'h1;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!nrst_in) begin
            flash_cnt <= 32'h0;
            flash_phase <= 1'b0;
        end else if (flash_cnt == 32'(FLASH_CYC - 1)) begin
            flash_cnt <= 32'h0;
            flash_phase <= !flash_phase;
        end else begin
            flash_cnt <= flash_cnt + 32'h1;
        end
    end

    // ----------------------------------------------------------------
    // Mode sequence
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_in) begin
        if (!nrst_in) begin
            state <= S_TEST;
        end else begin
            unique case (state)
                S_TEST: if (boot_end) state <= S_SWTYPE;
                S_SWTYPE: if (boot_end) state <= S_SWVER;
                S_SWVER: if (boot_end) state <= S_OPER;
                S_OPER: if (keys.prog) state <= S_MENU;
                S_MENU: begin
                    if (timeout) begin
                        state <= S_OPER;
                    end else if (keys.prog) begin
                        unique case (sel)
                            ITEM_END: state <= S_OPER;
                            ITEM_LIMLO: state <= S_NUM;
                            ITEM_TYPE, ITEM_KEYF: state <= S_CHOICE;
                        endcase
                    end
                end
                S_CHOICE: begin
                    if (timeout) state <= S_OPER;
                    else if (keys.prog) state <= S_MENU;
                end
                S_NUM: begin
                    if (timeout) state <= S_OPER;
                    else if (num_done) state <= S_MENU;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Menu selection and pending values
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_in) begin
        if (!nrst_in) begin
            sel <= ITEM_TYPE;
            pend_choice <= 3'h0;
            pend_dig <= '0;
            dig_idx <= 2'h0;
        end else if (state == S_OPER) begin
            sel <= ITEM_TYPE;
        end else if (state == S_MENU && keys.prog) begin
            pend_choice <= (sel == ITEM_TYPE) ? in_type_out : {1'b0, keyf_out};
            pend_dig <= lim_lo_out;
            dig_idx <= 2'h0;
        end else if (state == S_MENU) begin
            if (keys.plus) sel <= pmkd_item_t'(sel + 2'h1);
            else if (keys.minus) sel <= pmkd_item_t'(sel - 2'h1);
        end else if (state == S_CHOICE && !keys.prog && (keys.plus || keys.minus)) begin
            if (keys.plus) begin
                pend_choice <= (pend_choice == (sel == ITEM_TYPE ? `PMKD_N_TYPES
                    : `PMKD_N_KEYF) - 3'h1) ? 3'h0 : pend_choice + 3'h1;
            end else begin
                pend_choice <= (pend_choice != 3'h0) ? pend_choice - 3'h1
                    : (sel == ITEM_TYPE ? `PMKD_N_TYPES : `PMKD_N_KEYF) - 3'h1;
            end
        end else if (state == S_NUM) begin
            if (keys.prog) begin
                dig_idx <= dig_idx + 2'h1;
            end else if (keys.plus || keys.minus) begin
                pend_dig[dig_idx] <= step_digit(pend_dig[dig_idx], keys.plus,
                    dig_idx == `PMKD_DIGIT_TOP);
            end
        end
    end

    // ----------------------------------------------------------------
    // Stored settings
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_in) begin
        if (!nrst_in) begin
            in_type_out <= IT_VOLT;
            keyf_out <= KF_MINMAX;
            lim_lo_out <= '0;
        end else if (state == S_CHOICE && (keys.prog || timeout)) begin
            if (sel == ITEM_TYPE) in_type_out <= pmkd_in_type_t'(pend_choice);
            else keyf_out <= pmkd_keyf_t'(pend_choice[1:0]);
        end else if (num_done || (state == S_NUM && timeout)) begin
            lim_lo_out <= pend_dig;
        end else if (state == S_OPER && keyf_out == KF_LIMIT && !keys.prog
                     && (keys.plus || keys.minus)) begin
            lim_lo_out <= step_value(lim_lo_out, keys.plus);
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!nrst_in) begin
            path_sel_out <= 5'h01;
        end else begin
            path_sel_out <= 5'h01 << in_type_out;
        end
    end

    // ----------------------------------------------------------------
    // Operating-mode key functions
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_in) begin
        if (!nrst_in || state != S_OPER || keys.prog) begin
            recall <= RC_LIVE;
            lim_show <= 1'b0;
        end else if (keyf_out == KF_MINMAX) begin
            if (keys.plus) recall <= (recall == RC_MAX) ? RC_LIVE : RC_MAX;
            else if (keys.minus) recall <= (recall == RC_MIN) ? RC_LIVE : RC_MIN;
        end else if (keyf_out == KF_LIMIT) begin
            if (keys.plus || keys.minus) lim_show <= 1'b1;
            else if (idle_end) lim_show <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Display and indicators
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_in) begin
        if (!nrst_in) begin
            disp_out <= {4{`PMKD_SYM_ALL}};
            disp_blank_out <= 1'b0;
        end else begin
            disp_blank_out <= flash_on && flash_phase;
            unique case (state)
                S_TEST: disp_out <= {4{`PMKD_SYM_ALL}};
                S_SWTYPE: disp_out <= SW_TYPE;
                S_SWVER: disp_out <= SW_VER;
                S_OPER: begin
                    if (lim_show) disp_out <= lim_lo_out;
                    else if (recall == RC_MIN) disp_out <= min_digits_in;
                    else if (recall == RC_MAX) disp_out <= max_digits_in;
                    else if (meas_over_in) disp_out <= {4{`PMKD_SYM_BAR_HI}};
                    else if (meas_under_in) disp_out <= {4{`PMKD_SYM_BAR_LO}};
                    else disp_out <= meas_digits_in;
                end
                S_MENU: disp_out <= {`PMKD_SYM_PROG, {2{`PMKD_SYM_BLANK}}, {3'h0, sel}};
                S_CHOICE: disp_out <= {{3{`PMKD_SYM_BLANK}}, {2'h0, pend_choice}};
                S_NUM: disp_out <= pend_dig;
            endcase
        end
    end

    for (genvar i = 0; i < 2; i++) begin : g_led
        always_ff @(posedge clk_sys_in) begin
            if (!nrst_in) sp_led_out[i] <= 1'b0;
            else sp_led_out[i] <= sp_active_in[i] && flash_phase;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!nrst_in) begin
            switch_output_one_out <= 1'b0;
            switch_output_two_out <= 1'b0;
        end else begin
            switch_output_one_out <= sp_active_in[0];
            switch_output_two_out <= sp_active_in[1];
        end
    end

    // ----------------------------------------------------------------
    // Counter reset input
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_in) begin
        if (!nrst_in) begin
            cr_q1 <= 1'b0;
            cr_q2 <= 1'b0;
            cr_q3 <= 1'b0;
            cr_stable <= 1'b0;
            count_clear_out <= 1'b0;
        end else begin
            cr_q1 <= count_reset_in;
            cr_q2 <= cr_q1;
            cr_q3 <= cr_q2;
            if (cr_q2 == cr_q3) cr_stable <= cr_q3;
            count_clear_out <= cr_q2 && cr_q3 && !cr_stable && in_type_out == IT_PULSE;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    property p_timeout;
        @(posedge clk_sys_in) disable iff (!nrst_in)
        (in_param && idle_end && !any_key) |=> state == S_OPER;
    endproperty
    a_timeout: assert property (p_timeout) else $error("no return after idle");
    property p_flash_idle;
        @(posedge clk_sys_in) disable iff (!nrst_in)
        (state == S_MENU) |=> !disp_blank_out;
    endproperty
    a_flash_idle: assert property (p_flash_idle) else $error("menu flashes");
    property p_enter;
        @(posedge clk_sys_in) disable iff (!nrst_in)
        (state == S_OPER && keys.prog) |=> state == S_MENU ##1 sel == ITEM_TYPE;
    endproperty
    a_enter: assert property (p_enter) else $error("program key ignored");
    property p_menu_step;
        @(posedge clk_sys_in) disable iff (!nrst_in)
        (state == S_MENU && keys.plus && !keys.prog && !timeout)
            |=> sel == pmkd_item_t'($past(sel) + 2'h1);
    endproperty
    a_menu_step: assert property (p_menu_step) else $error("menu step wrong");
    property p_recall;
        @(posedge clk_sys_in) disable iff (!nrst_in)
        (state == S_OPER && keyf_out == KF_MINMAX && keys.plus && !keys.prog
            && recall == RC_LIVE) |=> recall == RC_MAX ##1 disp_out == $past(max_digits_in);
    endproperty
    a_recall: assert property (p_recall) else $error("max not recalled");
    property p_led;
        @(posedge clk_sys_in) disable iff (!nrst_in)
        !sp_active_in[1] |=> !sp_led_out[1];
    endproperty
    a_led: assert property (p_led) else $error("idle led lit");
    property p_bars;
        @(posedge clk_sys_in) disable iff (!nrst_in)
        (state == S_OPER && recall == RC_LIVE && !lim_show && meas_over_in)
            |=> disp_out == {4{`PMKD_SYM_BAR_HI}};
    endproperty
    a_bars: assert property (p_bars) else $error("overflow not shown");
    property p_num_done;
        @(posedge clk_sys_in) disable iff (!nrst_in)
        (num_done && !timeout) |=> state == S_MENU && lim_lo_out == $past(pend_dig);
    endproperty
    a_num_done: assert property (p_num_done) else $error("entry not saved");
    property p_sign;
        @(posedge clk_sys_in) disable iff (!nrst_in)
        (state == S_NUM && dig_idx != `PMKD_DIGIT_TOP) |-> pend_dig[dig_idx] != `PMKD_SYM_MINUS;
    endproperty
    a_sign: assert property (p_sign) else $error("sign off leftmost digit");
    property p_boot;
        @(posedge clk_sys_in) disable iff (!nrst_in)
        (state == S_TEST && boot_tmr != 32'(TEST_CYC - 1)) |=> state == S_TEST;
    endproperty
    a_boot: assert property (p_boot) else $error("segment test cut short");
    property p_swver;
        @(posedge clk_sys_in) disable iff (!nrst_in)
        (state == S_SWVER) |=> disp_out == SW_VER;
    endproperty
    a_swver: assert property (p_swver) else $error("version not shown");
    property p_path;
        @(posedge clk_sys_in) disable iff (!nrst_in)
        ##1 $stable(in_type_out) |-> path_sel_out == 5'h01 << in_type_out;
    endproperty
    a_path: assert property (p_path) else $error("input path mismatch");
    property p_clear;
        @(posedge clk_sys_in) disable iff (!nrst_in)
        count_clear_out |-> $past(in_type_out) == IT_PULSE ##1 !count_clear_out;
    endproperty
    a_clear: assert property (p_clear) else $error("bad count clear");

    c_boot: cover property (@(posedge clk_sys_in) disable iff (!nrst_in)
        state == S_SWVER ##1 state == S_OPER);
    c_entry: cover property (@(posedge clk_sys_in) disable iff (!nrst_in) num_done);
    c_timeout: cover property (@(posedge clk_sys_in) disable iff (!nrst_in) timeout);
    c_clear: cover property (@(posedge clk_sys_in) disable iff (!nrst_in) count_clear_out);
endmodule
`default_nettype wire

// *** test/pmkd_operator.sv ***
// Operator model: presses the three front keys with contact bounce.
// Assumes keys are active high and the bench calls press() off the clock edge.
`timescale 1ns/1ps
`default_nettype none
module pmkd_operator #(
    // Must exceed the three sync stages plus the debounce count of the meter.
    parameter int HOLD = 40
) (
    // Clock
    input wire logic clk_in,
    // Raw keys towards the meter
    output logic [2:0] key_raw_out
);
    initial key_raw_out = 3'h0;
    // One short bounce, then a long stable hold, then a release long enough to settle.
    task automatic press(input int k);
        key_raw_out[k] = 1'b1;
        @(posedge clk_in) #1 key_raw_out[k] = 1'b0;
        @(posedge clk_in) #1 key_raw_out[k] = 1'b1;
        repeat (HOLD) @(posedge clk_in);
        #1 key_raw_out[k] = 1'b0;
        repeat (HOLD) @(posedge clk_in);
        #1;
    endtask
endmodule
`default_nettype wire

// *** test/panel_meter_key_display_control_test.sv ***
// Self-checking bench of pmkd_core with shortened counts.
// Assumes the operator model drives the keys; min and max digits are constants.
`timescale 1ns/1ps
`default_nettype none
module panel_meter_key_display_control_test;
import pmkd_pkg::*;
logic clk_sys_in = 1'b0, nrst_in = 1'b0, clr_pin = 1'b0, ovr = 1'b0, und = 1'b0;
logic [1:0] sp = 2'h0, sw;
wire logic [2:0] keys;
wire pmkd_disp_t disp;
wire logic [2:0] it;
wire logic [4:0] path;
wire logic clr, blank;
wire logic [1:0] led, keyf;
wire pmkd_disp_t lim;
pmkd_disp_t live = 20'h0_8864, mx = 20'h1_0C63, mn = 20'h2_98E8;
logic [23:0] rows [4] = '{{4'h0, 20'h0_8864}, {4'h9, 20'h5_AD6B},
    {4'h6, 20'h6_318C}, {4'hF, 20'h5_AD6B}};
int miscompares = 0, total_checks = 0, cyc = 0;
always #50 clk_sys_in = ~clk_sys_in;
pmkd_operator i_op (.clk_in(clk_sys_in), .key_raw_out(keys));
pmkd_core #(.CYC_PER_MS(1)) i_dut (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
    .key_raw_in(keys), .meas_digits_in(live), .min_digits_in(mn), .max_digits_in(mx),
    .meas_over_in(ovr), .meas_under_in(und), .sp_active_in(sp), .count_reset_in(clr_pin),
    .disp_out(disp), .disp_blank_out(blank), .sp_led_out(led), .switch_output_one_out(sw[0]),
    .switch_output_two_out(sw[1]), .in_type_out(it), .path_sel_out(path), .keyf_out(keyf),
    .lim_lo_out(lim), .count_clear_out(clr));
task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    total_checks++;
    if (got !== exp) begin
        miscompares++;
        $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
endtask
task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
endtask
task automatic step(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
endtask
always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (cyc == 25000) begin
        miscompares++;
        stop_test();
    end
end
initial begin
    step(4);
    chk(disp, 20'h6_B5AD);
    chk(20'({it, path}), 20'h01);
    chk(20'({keyf, blank, led}), 20'h08);
    chk(lim, 20'h0_0000);
    nrst_in = 1'b1;
    step(500);
    chk(disp, 20'h6_B5AD);
    step(1000);
    chk(disp, 20'h0_8421);
    step(1000);
    chk(disp, 20'h0_0401);
    step(1000);
    foreach (rows[i]) begin
        {ovr, und, sp} = rows[i][23:20];
        step(2);
        chk(disp, rows[i][19:0]);
        chk(20'(sw), 20'(rows[i][21:20]));
    end
    {ovr, und, sp} = 4'h3;
    repeat (1100) if (led !== 2'h3) step(1);
    chk(20'(led), 20'h3);
    repeat (600) if (led !== 2'h0) step(1);
    chk(20'(led), 20'h0);
    sp = 2'h0;
    i_op.press(1);
    chk(disp, mx);
    i_op.press(1);
    chk(disp, live);
    i_op.press(2);
    chk(disp, mn);
    i_op.press(2);
    chk(disp, live);
    i_op.press(0);
    chk(disp, 20'h7_B9C0);
    chk(20'(blank), 20'h0);
    i_op.press(0);
    repeat (1100) if (blank !== 1'b1) step(1);
    chk(20'(blank), 20'h1);
    repeat (4) i_op.press(1);
    i_op.press(0);
    chk(20'({it, path}), 20'h90);
    clr_pin = 1'b1;
    repeat (10) if (clr !== 1'b1) step(1);
    chk(20'(clr), 20'h1);
    i_op.press(1);
    i_op.press(0);
    i_op.press(1);
    i_op.press(0);
    chk(20'(keyf), 20'h2);
    i_op.press(1);
    i_op.press(0);
    i_op.press(2);
    chk(disp, 20'h0_0009);
    repeat (3) i_op.press(0);
    i_op.press(2);
    i_op.press(0);
    chk(lim, 20'h5_0009);
    i_op.press(1);
    i_op.press(0);
    i_op.press(1);
    chk(disp, 20'h5_0008);
    i_op.press(0);
    i_op.press(0);
    i_op.press(2);
    step(10100);
    chk(20'({it, path}), 20'h68);
    chk(disp, live);
    stop_test();
end
endmodule
`default_nettype wire
